// ---- core/sif_edge.sv ----
`timescale 1ns/1ps
`include "sif_defs.svh"

// rising-edge detector, one pulse per zero-to-one change
module sif_edge
    import sif_pkg::*;
#(
    parameter int W = `SIF_NSRC
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] lvl,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] held
);
    typedef struct packed {
        logic [W-1:0] prev;
    } sif_edge_s;

    sif_edge_s st_q;
    sif_edge_s st_d;

    // previous level, reset to zero, so a level high out of reset gives an edge here
    always_comb begin
        st_d      = st_q;
        st_d.prev = lvl;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rise = lvl & ~st_q.prev;
    assign held = st_q.prev;
endmodule

// ---- core/sif_irq_ctrl.sv ----
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "sif_defs.svh"

// How it works
// - write one to set bits 5/4 enables loop out-of-bounds/ready irq
// - set bits 3..0 enable the four oscillator ready interrupts
// - zeros written to enable-set leave enables unchanged
// - irq raised while any flag and its enable are both set
// - flag register at 0x08, 32 bits, resets to zero
// - each flag sets on a rise of its status bit
// - writing one clears a flag, zero leaves it
// - phase loop timeout, fall, rise flags at bits 17, 16, 15
// - brown-out sync-ready, detect, ready flags at bits 11, 10, 9
// - lock-rise flag sets on rise; irq only with its enable
// - fuse may preset flags; software clears them before enabling
// - set bits 17..15 enable the phase loop interrupts
// - flags 8..0 set on rise of loop/oscillator status bits
// - status register at 0x0c is read-only source status
module sif_irq_ctrl
    import sif_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic [17:0] src_status,
    input  wire logic [17:0] fuse_preset,
    output logic      [31:0] rdata,
    output logic             irq
);
    // all checks below run on the one system clock and idle in reset
    default clocking cb_chk @(posedge clk); endclocking
    default disable iff (rst);

    // ************************************************************
    // source conditioning
    // ************************************************************
    sif_src_t stat_s;
    sif_src_t rise_s;

    sif_sync #(
        .W (`SIF_NSRC)
    ) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (src_status),
        .dout (stat_s)
    );

    sif_edge #(
        .W (`SIF_NSRC)
    ) u_edge (
        .clk  (clk),
        .rst  (rst),
        .lvl  (stat_s),
        .rise (rise_s),
        .held ()
    );

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        sif_phase_e  phase;
        sif_src_t    flags;
        sif_src_t    enable;
        logic [31:0] rdata;
        logic        irq;
    } sif_ctrl_s;

    sif_ctrl_s st_q;
    sif_ctrl_s st_d;

    // one function for the word that an offset reads back
    function automatic logic [31:0] rd_word(
        input logic [7:0] a,
        input sif_src_t   fl,
        input sif_src_t   en,
        input sif_src_t   sts
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            `SIF_OFS_ENCLR: w = {14'h0000, en};
            `SIF_OFS_ENSET: w = {14'h0000, en};
            `SIF_OFS_FLAGS: w = {14'h0000, fl};
            `SIF_OFS_STATUS: w = {14'h0000, sts};
            default:        w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    logic wr_flags;
    logic wr_enset;
    logic wr_enclr;
    sif_src_t wmask;

    assign wr_flags = wr && (addr == `SIF_OFS_FLAGS);
    assign wr_enset = wr && (addr == `SIF_OFS_ENSET);
    assign wr_enclr = wr && (addr == `SIF_OFS_ENCLR);
    // unimplemented bits never store
    assign wmask = wdata[17:0] & sif_src_t'(`SIF_IMPL_MASK);

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        st_d = st_q;
        case (st_q.phase)
            SIF_BOOT: begin
                // preset flags caught one cycle after reset release
                st_d.flags = fuse_preset & sif_src_t'(`SIF_IMPL_MASK);
                st_d.phase = SIF_RUN;
            end
            SIF_RUN: begin
                // clear by one first, so a same-cycle rise still wins
                if (wr_flags) begin
                    st_d.flags = st_q.flags & ~wmask;
                end
                st_d.flags = st_d.flags
                           | (rise_s & sif_src_t'(`SIF_IMPL_MASK));
            end
            default: st_d.phase = SIF_RUN;
        endcase
        // only ones written take effect
        if (wr_enset) begin
            st_d.enable = st_q.enable | wmask;
        end
        if (wr_enclr) begin
            st_d.enable = st_q.enable & ~wmask;
        end
        st_d.rdata = rd ? rd_word(addr, st_q.flags, st_q.enable, stat_s)
                        : 32'h0000_0000;
        st_d.irq = |(st_d.flags & st_d.enable);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q.phase  <= SIF_BOOT;
            st_q.flags  <= sif_src_t'(`SIF_RST_FLAGS);
            st_q.enable <= sif_src_t'(`SIF_RST_ENABLE);
            st_q.rdata  <= 32'h0000_0000;
            st_q.irq    <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata = st_q.rdata;
    assign irq   = st_q.irq;

    // ************************************************************
    // checks
    // ************************************************************
    // a flag-register write with a one in bit b
    sequence s_wr_one_flag(int b);
        wr && addr == `SIF_OFS_FLAGS && wdata[b];
    endsequence

    // a flag-register write with a zero in bit b
    sequence s_wr_zero_flag(int b);
        wr && addr == `SIF_OFS_FLAGS && !wdata[b];
    endsequence

    // an enable-set write with a one in bit b
    sequence s_set_one_en(int b);
        wr && addr == `SIF_OFS_ENSET && wdata[b];
    endsequence

    // an enable-set write with a zero in bit b
    sequence s_set_zero_en(int b);
        wr && addr == `SIF_OFS_ENSET && !wdata[b];
    endsequence

    // a synced status rise while the block runs
    sequence s_rise(int b);
        st_q.phase == SIF_RUN && rise_s[b];
    endsequence

    // no synced status rise while the block runs
    sequence s_quiet(int b);
        st_q.phase == SIF_RUN && !rise_s[b];
    endsequence

    // irq is the registered or of flag and enable pairs
    AST_IRQ_MATCH: assert property (
        irq == |(st_q.flags & st_q.enable))
        else $error("irq does not follow flags and enables");

    // a lock rise seen on the synced level lands in its flag
    AST_RISE_SETS: assert property (
        st_q.phase == SIF_RUN && $rose(stat_s[`SIF_BIT_LCKR])
        |=> st_q.flags[`SIF_BIT_LCKR])
        else $error("lock-rise flag missed a rise");

    // write one clears when no rise competes
    AST_W1C_CLEARS: assert property (
        (s_wr_one_flag(`SIF_BIT_BDET) and s_quiet(`SIF_BIT_BDET))
        |=> !st_q.flags[`SIF_BIT_BDET])
        else $error("write one did not clear flag");

    AST_W1C_LTO: assert property (
        (s_wr_one_flag(`SIF_BIT_LTO) and s_quiet(`SIF_BIT_LTO))
        |=> !st_q.flags[`SIF_BIT_LTO])
        else $error("write one did not clear timeout flag");

    AST_W1C_LCKF: assert property (
        (s_wr_one_flag(`SIF_BIT_LCKF) and s_quiet(`SIF_BIT_LCKF))
        |=> !st_q.flags[`SIF_BIT_LCKF])
        else $error("write one did not clear lock-fall flag");

    AST_W1C_BSYNC: assert property (
        (s_wr_one_flag(`SIF_BIT_BSYNC) and s_quiet(`SIF_BIT_BSYNC))
        |=> !st_q.flags[`SIF_BIT_BSYNC])
        else $error("write one did not clear sync-ready flag");

    AST_W1C_BRDY: assert property (
        (s_wr_one_flag(`SIF_BIT_BRDY) and s_quiet(`SIF_BIT_BRDY))
        |=> !st_q.flags[`SIF_BIT_BRDY])
        else $error("write one did not clear brown-out ready flag");

    AST_W1C_FRDY: assert property (
        (s_wr_one_flag(`SIF_BIT_FRDY) and s_quiet(`SIF_BIT_FRDY))
        |=> !st_q.flags[`SIF_BIT_FRDY])
        else $error("write one did not clear loop ready flag");

    // zeros written leave a set flag alone
    AST_W0_KEEPS: assert property (
        (s_wr_zero_flag(`SIF_BIT_LTO)
         and (st_q.phase == SIF_RUN && st_q.flags[`SIF_BIT_LTO]))
        |=> st_q.flags[`SIF_BIT_LTO])
        else $error("write zero disturbed a flag");

    AST_W0_KEEPS_LOW: assert property (
        (s_wr_zero_flag(`SIF_BIT_XTAL)
         and (st_q.phase == SIF_RUN && st_q.flags[`SIF_BIT_XTAL]))
        |=> st_q.flags[`SIF_BIT_XTAL])
        else $error("write zero disturbed a low flag");

    // an event is never lost to a clear in the same cycle
    AST_SET_WINS: assert property (
        (s_wr_one_flag(`SIF_BIT_RC8M) and s_rise(`SIF_BIT_RC8M))
        |=> st_q.flags[`SIF_BIT_RC8M])
        else $error("clear beat a same-cycle rise");

    AST_RISE_LTO: assert property (
        s_rise(`SIF_BIT_LTO) |=> st_q.flags[`SIF_BIT_LTO])
        else $error("timeout flag missed a rise");

    AST_RISE_BDET: assert property (
        s_rise(`SIF_BIT_BDET) |=> st_q.flags[`SIF_BIT_BDET])
        else $error("detect flag missed a rise");

    AST_RISE_FRDY: assert property (
        s_rise(`SIF_BIT_FRDY) |=> st_q.flags[`SIF_BIT_FRDY])
        else $error("loop ready flag missed a rise");

    // while the block runs a flag only appears on a rise, never by itself
    for (genvar g = 0; g < `SIF_NSRC; g++) begin : g_spur
        AST_NO_SPUR: assert property (
            (s_quiet(g) and !st_q.flags[g]) |=> !st_q.flags[g])
            else $error("flag set without a rise");
    end

    // enable-set ones take effect on the next cycle
    AST_ENSET_SETS: assert property (
        s_set_one_en(`SIF_BIT_FOOB) |=> st_q.enable[`SIF_BIT_FOOB])
        else $error("enable-set one ignored");

    AST_ENSET_FRDY: assert property (
        s_set_one_en(`SIF_BIT_FRDY) |=> st_q.enable[`SIF_BIT_FRDY])
        else $error("loop ready enable not set");

    AST_ENSET_XTAL: assert property (
        s_set_one_en(`SIF_BIT_XTAL) |=> st_q.enable[`SIF_BIT_XTAL])
        else $error("crystal ready enable not set");

    AST_ENSET_PLL: assert property (
        s_set_one_en(`SIF_BIT_LTO) |=> st_q.enable[`SIF_BIT_LTO])
        else $error("timeout enable not set");

    AST_ENSET_LCKR: assert property (
        s_set_one_en(`SIF_BIT_LCKR) |=> st_q.enable[`SIF_BIT_LCKR])
        else $error("lock-rise enable not set");

    // zeros written to enable-set never clear an enable
    AST_ENSET_ZERO: assert property (
        (s_set_zero_en(`SIF_BIT_RC8M) and st_q.enable[`SIF_BIT_RC8M])
        |=> st_q.enable[`SIF_BIT_RC8M])
        else $error("enable-set zero cleared enable");

    // unimplemented flag bits read zero
    AST_RESERVED_ZERO: assert property (
        rd && addr == `SIF_OFS_FLAGS |=> rdata[14:12] == 3'h0
        && rdata[31:18] == 14'h0000)
        else $error("reserved flag bits not zero");

    // and never store anything
    AST_RESERVED_STORE: assert property (
        (st_q.flags & ~sif_src_t'(`SIF_IMPL_MASK)) == 18'h00000)
        else $error("reserved flag bit stored");

    // flag read returns the flags of the strobe cycle
    AST_FLAG_READ: assert property (
        rd && addr == `SIF_OFS_FLAGS
        |=> rdata == {14'h0000, $past(st_q.flags)})
        else $error("flag read mismatch");

    AST_STATUS_READ: assert property (
        rd && addr == `SIF_OFS_STATUS |=> rdata[17:0] == $past(stat_s))
        else $error("status read mismatch");

    // preset comes from the fuse lines, masked, once after reset
    AST_BOOT_LOAD: assert property (
        st_q.phase == SIF_BOOT |=> st_q.flags
        == ($past(fuse_preset) & sif_src_t'(`SIF_IMPL_MASK)))
        else $error("preset flags not loaded");

    // a set and enabled lock-rise flag always requests
    AST_LCKR_IRQ: assert property (
        st_q.flags[`SIF_BIT_LCKR] && st_q.enable[`SIF_BIT_LCKR] |-> irq)
        else $error("enabled lock-rise flag without irq");
endmodule

// ---- core/sif_sync.sv ----
`timescale 1ns/1ps
`include "sif_defs.svh"

// two-stage synchroniser for the status bits from the analog sources
module sif_sync
    import sif_pkg::*;
#(
    parameter int W = `SIF_NSRC
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sif_sync_s;

    sif_sync_s st_q;
    sif_sync_s st_d;

    // first stage feeds only the second
    always_comb begin
        st_d    = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.s2;
endmodule

// ---- include/sif_defs.svh ----
`ifndef SIF_DEFS_SVH
`define SIF_DEFS_SVH

// ************************************************************
// register map
// ************************************************************
`define SIF_OFS_ENCLR    8'h00
`define SIF_OFS_ENSET    8'h04
`define SIF_OFS_FLAGS    8'h08
`define SIF_OFS_STATUS   8'h0c
`define SIF_OFS_FUSE     8'h10
`define SIF_RST_FLAGS    32'h0000_0000
`define SIF_RST_ENABLE   32'h0000_0000

// ************************************************************
// field layout
// ************************************************************
`define SIF_NSRC         18
`define SIF_BIT_XTAL     0
`define SIF_BIT_X32K     1
`define SIF_BIT_RC32K    2
`define SIF_BIT_RC8M     3
`define SIF_BIT_FRDY     4
`define SIF_BIT_FOOB     5
`define SIF_BIT_LTO      17
`define SIF_BIT_LCKF     16
`define SIF_BIT_LCKR     15
`define SIF_BIT_BSYNC    11
`define SIF_BIT_BDET     10
`define SIF_BIT_BRDY     9
// implemented source bits: 17..15 and 11..0
`define SIF_IMPL_MASK    18'h38fff

`endif

// ---- include/sif_pkg.sv ----
package sif_pkg;
    typedef logic [17:0] sif_src_t;
    typedef enum logic [0:0] {
        SIF_BOOT = 1'b0,
        SIF_RUN  = 1'b1
    } sif_phase_e;
endpackage

// ---- tb/sif_src_model.sv ----
`timescale 1ns/1ps

// status sources: a level follows the request after lag cycles, so the
// same model stands in for prompt and for slow sources
module sif_src_model (
    input  wire logic        clk,
    input  wire logic [3:0]  lag,
    input  wire logic [17:0] req,
    output logic      [17:0] status
);
    logic [17:0] pipe [16];

    // short delay line behind the request
    always_ff @(posedge clk) begin
        pipe[0] <= req;
        for (int i = 1; i < 16; i++) begin
            pipe[i] <= pipe[i-1];
        end
    end

    // levels whose rises are the events
    assign status = (lag == 4'h0) ? req : pipe[lag-4'h1];
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`include "sif_defs.svh"

module tb_top
    import sif_pkg::*;
;
    logic        clk, rst, wr, rd, irq;
    logic        pend = 1'b0;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, x, e;
    logic [3:0]  lag;
    sif_src_t    req, fuse, sts;
    logic [31:0] expq [$];
    int          n_errors, n_tests;

    sif_src_model src (.clk(clk), .lag(lag), .req(req), .status(sts));
    sif_irq_ctrl dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .src_status(sts), .fuse_preset(fuse),
        .rdata(rdata), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one idle edge after each access keeps strobes single-assigned
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] ex);
        expq.push_back(ex);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask

    // irq is a level; a stuck level ends the run after 8 cycles
    task automatic wait_irq(input logic ex);
        int i;
        i = 0;
        while (irq !== ex && i < 8) begin
            @(posedge clk);
            i++;
        end
        cmp({31'h0, irq}, {31'h0, ex});
        if (irq !== ex) complete_run();
    endtask

    // read data stand one cycle after the strobe: match the oldest note
    always @(posedge clk) begin
        if (pend) cmp(rdata, expq.pop_front());
        pend <= rd;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        {wr, rd, addr, wdata, lag, req} = '0;
        fuse = 18'h00210;
        x = 32'h1ab1a89c;
        n_errors = 0;
        n_tests = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rd_reg(`SIF_OFS_FLAGS, 32'h0000_0210);
        rd_reg(`SIF_OFS_ENSET, `SIF_RST_ENABLE);
        wait_irq(1'b0);
        wr_reg(`SIF_OFS_FLAGS, 32'h0000_0210);
        rd_reg(`SIF_OFS_FLAGS, `SIF_RST_FLAGS);
        $display("test preset done");
        // one source at a time; lag varies so slow sources are seen too
        for (int b = 0; b < 18; b++) begin
            if (((`SIF_IMPL_MASK >> b) & 18'h1) == 18'h0) continue;
            lag <= 4'(b % 4);
            req <= sif_src_t'(1) << b;
            repeat (8) @(posedge clk);
            rd_reg(`SIF_OFS_STATUS, 32'h1 << b);
            rd_reg(`SIF_OFS_FLAGS, 32'h1 << b);
            wait_irq(1'b0);
            wr_reg(`SIF_OFS_ENSET, 32'h1 << b);
            wait_irq(1'b1);
            req <= '0;
            wr_reg(`SIF_OFS_FLAGS, ~(32'h1 << b));
            rd_reg(`SIF_OFS_FLAGS, 32'h1 << b);
            wr_reg(`SIF_OFS_FLAGS, 32'h1 << b);
            wait_irq(1'b0);
        end
        wr_reg(`SIF_OFS_ENSET, 32'h0);
        rd_reg(`SIF_OFS_ENSET, {14'h0, `SIF_IMPL_MASK});
        // enable-clear path, then restore so the last test sees all
        wr_reg(`SIF_OFS_ENCLR, 32'h0000_8001);
        rd_reg(`SIF_OFS_ENCLR, {14'h0, `SIF_IMPL_MASK & ~18'h08001});
        wr_reg(`SIF_OFS_ENSET, 32'h0000_8001);
        rd_reg(`SIF_OFS_FUSE, 32'h0);
        $display("test sources done");
        // all sources rise together, then random write-one clears
        req <= `SIF_IMPL_MASK;
        repeat (8) @(posedge clk);
        e = {14'h0, `SIF_IMPL_MASK};
        rd_reg(`SIF_OFS_FLAGS, e);
        repeat (6) begin
            x = xs(x);
            wr_reg(`SIF_OFS_FLAGS, x);
            e = e & ~x;
            rd_reg(`SIF_OFS_FLAGS, e);
        end
        wait_irq(e != 32'h0);
        wr_reg(`SIF_OFS_FLAGS, 32'hffff_ffff);
        wait_irq(1'b0);
        $display("test random done");
        complete_run();
    end
endmodule
